/* File: lpst_map.vh */
// constants for the lvds pixel serializer transmitter
// How it works
// [RQ1] take 21 inputs per pixel: six red, six green, six blue, three timing lines
// [RQ2] drive serial pixel data on three lanes, each a true and complement output
// [RQ3] forward a locked copy of the pixel clock on its own pair
// [RQ4] while standby request is low, all pairs are released to high impedance
// [RQ5] standby resets the core, drops lock and holds it idle until release
// [RQ6] strobe select high samples on rising pixel edge, low on falling edge
// [RQ7] strobe select left open reads low, so falling edge is the default
// [RQ8] clock and data may start in any order after standby release
// [RQ9] a stopped then resumed pixel clock relocks without any standby cycle
// [RQ10] source should pulse standby after an unstable clock so lock can settle
// [RQ11] source should pulse standby whenever clock and data stop and restart
// [RQ12] track spread clocks up to 100kHz, +-2.5% centre or -5% down spread
// [RQ13] lock and valid outputs within 10 ms of a valid clock after release
// [RQ14] outputs reach the standby state within 100 ns of standby request
// [RQ15] seven bits per lane per pixel, fixed slot order aligned to forwarded clock
// [RQ16] with pixel clock missing and standby released, all pairs drive logic low
`ifndef LPST_MAP_VH
`define LPST_MAP_VH

// ***********************************************
// link shape
// ***********************************************
`define LPST_LANES         3
`define LPST_SLOTS         7
`define LPST_COLOR_BITS    6
`define LPST_PIXEL_BITS    21
`define LPST_SYNC_BITS     24
`define LPST_LAST_SLOT     3'h6
`define LPST_SLOT_STEP     17'h00007
`define LPST_CLK_PATTERN   7'h63

// ***********************************************
// timing
// ***********************************************
`define LPST_CLK_PERIOD_NS 10
`define LPST_PD_DELAY_NS   100
`define LPST_PD_DELAY_CYC  (`LPST_PD_DELAY_NS / `LPST_CLK_PERIOD_NS)
`define LPST_PD_PATH_CYC   3
`define LPST_LOCK_TIME_MS  10
`define LPST_LOCK_CYC      20'hF4240
`define LPST_LOSS_CYC      16'h00C8
`define LPST_STABLE_NEED   3'h4
`define LPST_CNT_MAX       16'hFFFF

// ***********************************************
// core states
// ***********************************************
`define LPST_ST_STANDBY    2'h0
`define LPST_ST_ACQUIRE    2'h1
`define LPST_ST_LOCKED     2'h2

`endif

/* File: lpst_sync2.v */
// two flop synchroniser for pins from outside the clk domain
`timescale 1ns/100ps
`default_nettype none
module lpst_sync2 #(
  parameter WIDTH = 1
)(
  // clock and reset
  input  wire             clk,
  input  wire             sys_rst,
  // pins and synchronised copies
  input  wire [WIDTH-1:0] async,
  output wire [WIDTH-1:0] synced
);

  // ***********************************************
  // one pair of flops per bit
  // ***********************************************
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : bitSync
      reg meta_r;
      reg hold_r;
      // first flop feeds only the second
      always @(posedge clk)
      begin
        if (sys_rst)
        begin
          meta_r <= 1'b0;
          hold_r <= 1'b0;
        end
        else
        begin
          meta_r <= async[i];
          hold_r <= meta_r;
        end
      end
      assign synced[i] = hold_r;
    end
  endgenerate

endmodule
`default_nettype wire

/* File: lpst_tx.v */
// lvds pixel serializer transmitter core
`timescale 1ns/100ps
`default_nettype none
`include "lpst_map.vh"
module lpst_tx #(
  parameter [19:0] LOCK_CYC = `LPST_LOCK_CYC
)(
  // clock and reset
  input  wire       clk,
  input  wire       sys_rst,
  // parallel pixel inputs
  input  wire [5:0] pixelRed,
  input  wire [5:0] pixelGreen,
  input  wire [5:0] pixelBlue,
  input  wire       lineSync,
  input  wire       frameSync,
  input  wire       displayEnable,
  input  wire       pixelClockInput,
  // straps and standby
  input  wire       strobeEdgeSelect,
  input  wire       standbyRequestN,
  // serial link
  output reg  [2:0] serialLaneTrue,
  output reg  [2:0] serialLaneComplement,
  output reg        forwardedClockTrue,
  output reg        forwardedClockComplement,
  output reg        linkOutEnableN,
  // status
  output reg        pllLocked
);

  // ***********************************************
  // pin synchronisers
  // ***********************************************
  wire [23:0] syncIn;
  wire [23:0] syncOut;
  wire [20:0] pixSync;
  wire        clkSync;
  wire        strobeSync;
  wire        standbySync;

  // pixel word packed lsb first: red, green, blue, line, frame, enable
  assign syncIn = {standbyRequestN, strobeEdgeSelect, pixelClockInput,
                   displayEnable, frameSync, lineSync,
                   pixelBlue, pixelGreen, pixelRed}; // RQ1

  lpst_sync2 #(
    .WIDTH (`LPST_SYNC_BITS)
  ) pinSync (
    .clk     (clk),
    .sys_rst (sys_rst),
    .async   (syncIn),
    .synced  (syncOut)
  );

  assign pixSync     = syncOut[20:0];
  assign clkSync     = syncOut[21];
  assign strobeSync  = syncOut[22];
  assign standbySync = syncOut[23];

  // standby acts as a full reset of the core
  wire coreRst;
  assign coreRst = sys_rst | ~standbySync; // RQ5

  // ***********************************************
  // strobe edge strap and pixel edge detect
  // ***********************************************
  reg clkPrev_r;
  reg edgeSel_r;
  reg strapCaught_r;
  wire riseEdge;
  wire fallEdge;
  wire sampleEdge;

  always @(posedge clk)
  begin
    if (coreRst)
    begin
      clkPrev_r     <= 1'b0;
      edgeSel_r     <= 1'b0; // RQ7
      strapCaught_r <= 1'b0;
    end
    else
    begin
      clkPrev_r <= clkSync;
      // strap is caught once after each release of standby
      if (!strapCaught_r)
      begin
        edgeSel_r     <= strobeSync; // RQ6
        strapCaught_r <= 1'b1;
      end
    end
  end

  assign riseEdge   = clkSync & ~clkPrev_r;
  assign fallEdge   = ~clkSync & clkPrev_r;
  assign sampleEdge = strapCaught_r & (edgeSel_r ? riseEdge : fallEdge); // RQ6

  // ***********************************************
  // period measurement and clock loss
  // ***********************************************
  reg  [15:0] sinceEdge_r;
  reg  [15:0] period_r;
  reg  [15:0] prevPeriod_r;
  reg         seenEdge_r;
  reg         periodValid_r;
  wire        clkLost;
  wire [15:0] periodNew;
  wire [15:0] periodDiff;
  wire        periodStable;

  assign periodNew  = sinceEdge_r + 16'h0001;
  assign periodDiff = (periodNew > period_r) ? (periodNew - period_r)
                                             : (period_r - periodNew);
  // 1/16 window plus one clk of sampling jitter, else short periods never settle
  assign periodStable = periodDiff <= ({4'h0, period_r[15:4]} + 16'h0001); // RQ12
  assign clkLost      = sinceEdge_r >= `LPST_LOSS_CYC; // RQ16

  always @(posedge clk)
  begin
    if (coreRst)
    begin
      sinceEdge_r   <= 16'h0000;
      period_r      <= 16'h0000;
      prevPeriod_r  <= 16'h0000;
      seenEdge_r    <= 1'b0;
      periodValid_r <= 1'b0;
    end
    else if (sampleEdge)
    begin
      sinceEdge_r <= 16'h0000;
      seenEdge_r  <= 1'b1;
      // every period is retaken, so a spread clock is tracked
      if (seenEdge_r)
      begin
        prevPeriod_r  <= period_r;
        period_r      <= periodNew; // RQ12
        periodValid_r <= 1'b1;
      end
    end
    else if (clkLost)
    begin
      // a stopped clock forgets its history and relocks later
      seenEdge_r    <= 1'b0; // RQ9
      periodValid_r <= 1'b0;
      sinceEdge_r   <= `LPST_LOSS_CYC;
    end
    else if (sinceEdge_r != `LPST_CNT_MAX)
    begin
      sinceEdge_r <= sinceEdge_r + 16'h0001;
    end
  end

  // ***********************************************
  // lock state machine
  // ***********************************************
  localparam [1:0] ST_STANDBY = `LPST_ST_STANDBY;
  localparam [1:0] ST_ACQUIRE = `LPST_ST_ACQUIRE;
  localparam [1:0] ST_LOCKED  = `LPST_ST_LOCKED;

  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [2:0]  stableCnt_r;
  reg  [19:0] waitCnt_r;
  wire        waitDone;

  assign waitDone = waitCnt_r >= (LOCK_CYC - 20'h00001);

  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_STANDBY:
        state_nxt = ST_ACQUIRE; // RQ8
      ST_ACQUIRE:
      begin
        if (!clkLost && periodValid_r &&
            (stableCnt_r >= `LPST_STABLE_NEED || waitDone))
          state_nxt = ST_LOCKED; // RQ13
      end
      ST_LOCKED:
      begin
        if (clkLost)
          state_nxt = ST_ACQUIRE; // RQ9
      end
      default:
        state_nxt = ST_STANDBY;
    endcase
  end

  always @(posedge clk)
  begin
    if (coreRst)
    begin
      state_r     <= ST_STANDBY; // RQ5
      stableCnt_r <= 3'h0;
      waitCnt_r   <= 20'h00000;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r != ST_ACQUIRE || clkLost || !seenEdge_r)
      begin
        // watchdog runs only while a clock is really present
        stableCnt_r <= 3'h0;
        waitCnt_r   <= 20'h00000;
      end
      else
      begin
        if (!waitDone)
          waitCnt_r <= waitCnt_r + 20'h00001; // RQ13
        if (sampleEdge && periodValid_r)
        begin
          if (!periodStable || prevPeriod_r == 16'h0000)
            stableCnt_r <= 3'h0;
          else if (stableCnt_r != `LPST_STABLE_NEED)
            stableCnt_r <= stableCnt_r + 3'h1;
        end
      end
    end
  end

  // ***********************************************
  // bit slot timing
  // ***********************************************
  // slots are spread over the measured period by a phase accumulator;
  // resolution is one clk, so slot edges jitter by up to 10 ns
  reg  [20:0] word_r;
  reg  [2:0]  slot_r;
  reg  [15:0] phase_r;
  reg         running_r;
  wire [16:0] phaseSum;
  wire        slotStep;

  assign phaseSum = {1'b0, phase_r} + `LPST_SLOT_STEP;
  assign slotStep = phaseSum >= {1'b0, period_r};

  always @(posedge clk)
  begin
    if (coreRst)
    begin
      word_r    <= 21'h000000;
      slot_r    <= 3'h0;
      phase_r   <= 16'h0000;
      running_r <= 1'b0;
    end
    else if (sampleEdge)
    begin
      word_r    <= pixSync; // RQ1
      slot_r    <= 3'h0; // RQ15
      phase_r   <= 16'h0000;
      running_r <= periodValid_r;
    end
    else if (clkLost)
    begin
      running_r <= 1'b0;
    end
    else if (slot_r != `LPST_LAST_SLOT)
    begin
      if (slotStep)
      begin
        phase_r <= phaseSum[15:0] - period_r;
        slot_r  <= slot_r + 3'h1; // RQ15
      end
      else
      begin
        phase_r <= phaseSum[15:0];
      end
    end
  end

  // ***********************************************
  // lane mapping
  // ***********************************************
  // lane 0: red 0-5, green 0; lane 1: green 1-5, blue 0-1;
  // lane 2: blue 2-5, line, frame, enable; slot n sends bit n
  wire [2:0] laneBit;
  wire [2:0] patIdx;
  wire       clkBit;

  genvar l;
  generate
    for (l = 0; l < `LPST_LANES; l = l + 1)
    begin : laneMap
      wire [6:0] laneWord;
      assign laneWord   = word_r[7*l +: 7];
      assign laneBit[l] = laneWord[slot_r]; // RQ15
    end
  endgenerate

  // forwarded clock high for slots 0,1,5,6 so its rise marks slot 5
  assign patIdx = `LPST_LAST_SLOT - slot_r;
  assign clkBit = |(`LPST_CLK_PATTERN & (7'h01 << patIdx)); // RQ3

  // ***********************************************
  // output drivers
  // ***********************************************
  // standby reaches the pins after two sync flops and this register,
  // well inside the allowed delay
  wire sending;
  assign sending = (state_r == ST_LOCKED) && running_r;

  always @(posedge clk)
  begin
    if (coreRst)
    begin
      linkOutEnableN           <= 1'b1; // RQ4
      serialLaneTrue           <= 3'h0; // RQ14
      serialLaneComplement     <= 3'h0;
      forwardedClockTrue       <= 1'b0;
      forwardedClockComplement <= 1'b0;
      pllLocked                <= 1'b0; // RQ5
    end
    else
    begin
      linkOutEnableN <= 1'b0;
      pllLocked      <= (state_r == ST_LOCKED);
      if (sending)
      begin
        serialLaneTrue           <= laneBit; // RQ2
        serialLaneComplement     <= ~laneBit; // RQ2
        forwardedClockTrue       <= clkBit; // RQ3
        forwardedClockComplement <= ~clkBit; // RQ3
      end
      else
      begin
        // no usable clock: every pair sits at logic low
        serialLaneTrue           <= 3'h0; // RQ16
        serialLaneComplement     <= 3'h7; // RQ16
        forwardedClockTrue       <= 1'b0;
        forwardedClockComplement <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

/* File: lpst_tx_checker.sv */
// assertions on the serializer core pins
`timescale 1ns/100ps
`default_nettype none
module lpst_tx_checker #(
  parameter [19:0] LOCK_CYC = 20'h007D0
)(
  // clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // inputs watched
  input wire logic       pixelClockInput,
  input wire logic       standbyRequestN,
  // link side
  input wire logic [2:0] serialLaneTrue,
  input wire logic [2:0] serialLaneComplement,
  input wire logic       forwardedClockTrue,
  input wire logic       forwardedClockComplement,
  input wire logic       linkOutEnableN,
  input wire logic       pllLocked
);
  logic [8:0]  stillCnt;
  logic [20:0] waitCnt;
  logic        pixPrev;
  // ages kept in counters, too long for a repetition
  always @(posedge clk)
  begin
    pixPrev <= pixelClockInput;
    if (sys_rst || pixelClockInput != pixPrev)
      stillCnt <= 9'h000;
    else if (stillCnt != 9'h1FF)
      stillCnt <= stillCnt + 9'h001;
    if (sys_rst || pllLocked || !standbyRequestN)
      waitCnt <= 21'h000000;
    else if (stillCnt < 9'h014)
      waitCnt <= waitCnt + 21'h000001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  a_standby_hiz: assert property ($fell(standbyRequestN) |-> ##[1:10] linkOutEnableN)
    else $error("link not released after standby");
  a_standby_hold: assert property (!standbyRequestN [*5] |-> linkOutEnableN && !pllLocked)
    else $error("link active in standby");
  a_pair_inverse: assert property (!linkOutEnableN |->
    serialLaneComplement == ~serialLaneTrue && forwardedClockComplement != forwardedClockTrue)
    else $error("pair halves not inverse");
  a_idle_low: assert property (!linkOutEnableN && !pllLocked && !$past(pllLocked) |->
    serialLaneTrue == 3'h0 && !forwardedClockTrue)
    else $error("unlocked link not low");
  a_clock_loss: assert property (stillCnt > 9'h0DC |-> !pllLocked)
    else $error("lock held without clock");
  a_lock_bound: assert property (waitCnt <= {1'b0, LOCK_CYC} + 21'h000064)
    else $error("lock took too long");
  a_fwd_low: assert property ($fell(forwardedClockTrue) && pllLocked |->
    !forwardedClockTrue [*3])
    else $error("forwarded clock low phase short");
  a_release_drive: assert property (standbyRequestN [*8] |-> !linkOutEnableN)
    else $error("link not driven after release");
endmodule
bind lpst_tx lpst_tx_checker #(.LOCK_CYC(LOCK_CYC)) chk_u (
  .clk(clk), .sys_rst(sys_rst), .pixelClockInput(pixelClockInput),
  .standbyRequestN(standbyRequestN), .serialLaneTrue(serialLaneTrue),
  .serialLaneComplement(serialLaneComplement), .forwardedClockTrue(forwardedClockTrue),
  .forwardedClockComplement(forwardedClockComplement),
  .linkOutEnableN(linkOutEnableN), .pllLocked(pllLocked)
);
`default_nettype wire

/* File: lpst_rx_model.sv */
// display receiver model decoding slots two and five
`timescale 1ns/100ps
`default_nettype none
module lpst_rx_model (
  // core clock
  input  wire logic       clk,
  // serial link
  input  wire logic [2:0] laneTrue,
  input  wire logic [2:0] laneComp,
  input  wire logic       fwdTrue,
  input  wire logic       fwdComp,
  input  wire logic       linkOutEnableN,
  // decoded bits
  output var  logic [5:0] rxWord,
  output var  logic       rxValid
);
  logic [2:0] midBits;
  logic [3:0] sinceFall;
  logic       fwdPrev;
  // differential decode, a released link reads idle
  wire  [2:0] laneBits = laneTrue & ~laneComp & {3{~linkOutEnableN}};
  wire        fwdBit   = fwdTrue & ~fwdComp & ~linkOutEnableN;
  // a rise long after a fall is a startup, not slot five
  always @(posedge clk)
  begin
    fwdPrev <= fwdBit;
    rxValid <= 1'b0;
    if (fwdPrev && !fwdBit)
    begin
      midBits   <= laneBits;
      sinceFall <= 4'h0;
    end
    else if (sinceFall != 4'hF)
      sinceFall <= sinceFall + 4'h1;
    if (!fwdPrev && fwdBit && sinceFall < 4'h9)
    begin
      rxWord  <= {midBits, laneBits};
      rxValid <= 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: lpst_tx_tb_top.sv */
// self-checking bench for the serializer core
`timescale 1ns/100ps
`default_nettype none
module lpst_tx_tb_top;
  logic       clk, sys_rst, pixClk, pixRun, standbyN, strapDrv;
  logic [5:0] red, green, blue, rxWord, pendWord;
  logic       lineS, frameS, dispEn, fwdT, fwdC, enN, locked, rxValid;
  logic [2:0] laneT, laneC;
  logic [5:0] noteQ[$];
  integer     n_errors, compares, seed, c0;
  wire        strapPin;
  pulldown (strapPin);
  assign strapPin = strapDrv;
  lpst_tx #(.LOCK_CYC(20'h007D0)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .pixelRed(red), .pixelGreen(green),
    .pixelBlue(blue), .lineSync(lineS), .frameSync(frameS), .displayEnable(dispEn),
    .pixelClockInput(pixClk), .strobeEdgeSelect(strapPin), .standbyRequestN(standbyN),
    .serialLaneTrue(laneT), .serialLaneComplement(laneC), .forwardedClockTrue(fwdT),
    .forwardedClockComplement(fwdC), .linkOutEnableN(enN), .pllLocked(locked)
  );
  lpst_rx_model rx_u (
    .clk(clk), .laneTrue(laneT), .laneComp(laneC), .fwdTrue(fwdT), .fwdComp(fwdC),
    .linkOutEnableN(enN), .rxWord(rxWord), .rxValid(rxValid)
  );
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // pixel clock stands still while not run
  initial
  begin
    pixClk = 1'b0;
    #3.3;
    forever
    begin
      #62.5;
      if (pixRun)
        pixClk = ~pixClk;
    end
  end
  task check(input logic [5:0] got, input logic [5:0] exp, input string what);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task end_of_test;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // capture at the strobe edge, keep it if lock shows half a period later
  always @(pixClk)
  begin
    if (pixClk == (strapPin === 1'b1))
      pendWord = {blue[4], green[3], red[2], frameS, blue[0], red[5]};
    else
    begin
      if (locked === 1'b1)
        noteQ.push_back(pendWord);
      tick(1);
      {red, green, blue, lineS, frameS, dispEn} = 21'($random(seed));
    end
  end
  always @(posedge clk)
    if (rxValid === 1'b1 && noteQ.size() > 0)
      check(rxWord, noteQ.pop_front(), "lane slots");
    else if (rxValid === 1'b1)
      check(6'h00, 6'h3F, "word with no note");
  task run_pixels(input string name);
    c0 = compares;
    pixRun = 1'b1;
    repeat (60) @(posedge pixClk);
    if (strapPin === 1'b1)
      @(negedge pixClk);
    tick(1);
    $display("test %s done", name);
  endtask
  task settle(input logic [5:0] exp);
    pixRun = 1'b0;
    tick(300);
    check({laneT, fwdT, enN, locked}, exp, "link after stop");
    check({5'h00, noteQ.size() == 0 && compares - c0 > 40}, 6'h01, "word count");
  endtask
  initial
  begin
    #500000;
    n_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    end_of_test;
  end
  initial
  begin
    seed = 32'h9D0D;
    n_errors = 0;
    compares = 0;
    sys_rst = 1'b1;
    standbyN = 1'b0;
    pixRun = 1'b0;
    strapDrv = 1'bz;
    {red, green, blue, lineS, frameS, dispEn} = 21'h000000;
    tick(8);
    sys_rst = 1'b0;
    tick(20);
    check({laneT, fwdT, enN, locked}, 6'h02, "standby state");
    standbyN = 1'b1;
    tick(30);
    check({laneT, fwdT, enN, locked}, 6'h00, "idle no clock");
    run_pixels("falling strobe");
    settle(6'h00);
    run_pixels("clock resumed");
    pixRun = 1'b0;
    tick(20);
    standbyN = 1'b0;
    tick(10);
    check({laneT, fwdT, enN, locked}, 6'h02, "standby delay");
    settle(6'h02);
    strapDrv = 1'b1;
    pixRun = 1'b1;
    tick(30);
    standbyN = 1'b1;
    run_pixels("rising strobe");
    settle(6'h00);
    end_of_test;
  end
endmodule
`default_nettype wire
